// >>> common/pa_ramp_consts.vh
`ifndef PA_RAMP_CONSTS_VH
`define PA_RAMP_CONSTS_VH
// ****************************************
// Register offsets
// ****************************************
`define ADDR_RX_FRONT_END   6'h21
`define ADDR_TX_FRONT_END   6'h22
`define ADDR_CAL_CHG_PUMP   6'h23
`define ADDR_CAL_VCO_CUR    6'h24
`define ADDR_TABLE_BASE     6'h38
`define ADDR_MODE_CTRL      6'h37
// ****************************************
// Reset values
// ****************************************
`define RST_RX_FRONT_END    8'h56
`define RST_TX_FRONT_END    8'h10
`define RST_CAL_CHG_PUMP    8'hA9
`define RST_CAL_VCO_CUR     8'h0A
`define RST_MODE_CTRL       8'h00
`define RST_TABLE_ENTRY     8'h00
// ****************************************
// Field layout and masks
// ****************************************
`define TX_WRITE_MASK       8'h37
`define VCO_WRITE_MASK      8'h3F
`define MODE_WRITE_MASK     8'h01
`define PIDX_MSB            2
`define PIDX_LSB            0
`define CP_CAL_EN_MSB       5
`define CP_CAL_EN_LSB       4
`define CP_CAL_EN_ON        2'h1
`define CP_CODE_MSB         3
`define CP_CODE_LSB         0
`define CP_EXP_SHIFT        2
`define VCO_HIGH_BIT        5
`define VCO_CUR_MSB         4
`define VCO_CUR_LSB         0
`define TXLO_MSB            5
`define TXLO_LSB            4
`define ASK_MODE_BIT        0
`endif

// >>> verilog/power_table_mem.v
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Eight-entry power lookup table
// ****************************************
module power_table_mem #(
  parameter DEPTH_LOG2 = 3,
  parameter WIDTH      = 8
) (
  input  wire                  i_clock,   // System clock
  input  wire                  i_we,      // Write enable
  input  wire [DEPTH_LOG2-1:0] i_waddr,   // Write index
  input  wire [WIDTH-1:0]      i_wdata,   // Write data
  input  wire [DEPTH_LOG2-1:0] i_raddr_a, // Bus read index
  output reg  [WIDTH-1:0]      o_rdata_a, // Registered bus read
  input  wire [DEPTH_LOG2-1:0] i_raddr_b, // Amplifier read index
  output reg  [WIDTH-1:0]      o_rdata_b  // Registered amp setting
);
  reg [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];

  // No reset on contents; software loads the table before transmit
  always @(posedge i_clock)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata_a <= mem[i_raddr_a];
    o_rdata_b <= mem[i_raddr_b];
  end
endmodule
`default_nettype wire

// >>> verilog/pa_ramp_index_and_synth_cal_regs.v
// Notes on behaviour
// RL1: Three-bit power index points into table
// RL2: Keyed one symbol uses indexed entry
// RL3: Keyed zero symbol uses entry zero
// RL4: Keyed shaping steps zero to index
// RL5: Ramp up at start, down at end
// RL6: Software may restore saved calibration values
// RL7: Charge-pump code is exponential, quarter-octave steps
// RL8: Charge-pump calibration runs when field equals one
// RL9: Bit five selects high oscillator core
// RL10: Oscillator current result, writable override, reset ten
// RL11: Software loads calibration configuration before calibration
// RL12: Transmit register: buffer current, power index
// RL13: Three receive trims reset to one
// RL14: Mixer trim resets to two, read/write
// RL15: Reserved bits read zero, writes ignored
`timescale 1ns/1ns
`default_nettype none
`include "pa_ramp_consts.vh"

module pa_ramp_index_and_synth_cal_regs #(
  parameter TABLE_LOG2 = 3,
  parameter ADDR_W     = 6
) (
  input  wire              i_clock,          // 250 MHz clock
  input  wire              i_rst,            // Sync reset, active high
  input  wire [ADDR_W-1:0] i_addr,           // Register address
  input  wire [7:0]        i_wdata,          // Write data
  input  wire              i_wr,             // Write strobe
  input  wire              i_rd,             // Read strobe
  output reg  [7:0]        o_rdata,          // Read data, next cycle
  input  wire              i_tx_active,      // Transmission in progress
  input  wire              i_symbol,         // Current keyed symbol
  input  wire              i_symbol_strobe,  // One pulse per symbol
  input  wire              i_cal_load,       // Calibration engine writes
  input  wire [3:0]        i_cal_cp_code,    // Engine charge-pump code
  input  wire [4:0]        i_cal_vco_cur,    // Engine oscillator current
  output reg  [7:0]        o_pa_setting,     // Amplifier setting
  output reg               o_pa_on,          // Amplifier enabled
  output reg  [3:0]        o_cp_exp_int,     // Integer part of exponent c/4
  output reg  [1:0]        o_cp_exp_frac,    // Quarter-octave fraction
  output reg               o_cp_cal_stage,   // Charge-pump stage enabled
  output reg               o_osc_core_high,  // High oscillator core
  output reg  [4:0]        o_osc_current,    // Oscillator current code
  output reg  [1:0]        o_tx_lo_buf,      // Transmit buffer current
  output reg  [7:0]        o_rx_trims        // Receive trims, packed
);
  // ****************************************
  // Configuration registers
  // ****************************************
  reg [7:0] rx_front_end_config_q;
  reg [7:0] tx_front_end_config_q;
  reg [7:0] synth_cal_charge_pump_q;
  reg [7:0] synth_cal_vco_current_q;
  reg [7:0] mode_ctrl_q;

  wire [TABLE_LOG2-1:0] power_index =
    tx_front_end_config_q[`PIDX_MSB:`PIDX_LSB];
  wire ask_mode = mode_ctrl_q[`ASK_MODE_BIT];
  // Table is one aligned block; only the upper address bits decide
  wire [ADDR_W-1:0] table_base = `ADDR_TABLE_BASE;
  wire table_hit = (i_addr[ADDR_W-1:TABLE_LOG2] ==
                    table_base[ADDR_W-1:TABLE_LOG2]);
  wire table_we  = i_wr && table_hit;

  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      // RL13: receive trims reset
      rx_front_end_config_q   <= `RST_RX_FRONT_END;
      // RL12: transmit register reset
      tx_front_end_config_q   <= `RST_TX_FRONT_END;
      // RL8: calibration enable reset
      synth_cal_charge_pump_q <= `RST_CAL_CHG_PUMP;
      // RL10: oscillator current reset
      synth_cal_vco_current_q <= `RST_CAL_VCO_CUR;
      mode_ctrl_q             <= `RST_MODE_CTRL;
    end
    else
    begin
      if (i_wr)
      begin
        case (i_addr)
          // RL14: mixer trim writable
          `ADDR_RX_FRONT_END: rx_front_end_config_q <= i_wdata;
          // RL15: reserved bits dropped
          `ADDR_TX_FRONT_END:
            tx_front_end_config_q <= i_wdata & `TX_WRITE_MASK;
          // RL6: saved values restored
          `ADDR_CAL_CHG_PUMP: synth_cal_charge_pump_q <= i_wdata;
          // RL10: software override
          `ADDR_CAL_VCO_CUR:
            synth_cal_vco_current_q <= i_wdata & `VCO_WRITE_MASK;
          `ADDR_MODE_CTRL:
            mode_ctrl_q <= i_wdata & `MODE_WRITE_MASK;
          default: ;
        endcase
      end
      // Engine result loads after bus write of same cycle
      if (i_cal_load)
      begin
        synth_cal_charge_pump_q[`CP_CODE_MSB:`CP_CODE_LSB] <= i_cal_cp_code;
        synth_cal_vco_current_q[`VCO_CUR_MSB:`VCO_CUR_LSB] <= i_cal_vco_cur;
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  wire [7:0] table_rdata;
  wire [7:0] table_pa_data;
  reg        table_rd_q;

  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_rdata    <= 8'h00;
      table_rd_q <= 1'b0;
    end
    else
    begin
      table_rd_q <= i_rd && table_hit;
      o_rdata    <= 8'h00;
      if (i_rd)
      begin
        case (i_addr)
          `ADDR_RX_FRONT_END: o_rdata <= rx_front_end_config_q;
          `ADDR_TX_FRONT_END: o_rdata <= tx_front_end_config_q;
          `ADDR_CAL_CHG_PUMP: o_rdata <= synth_cal_charge_pump_q;
          `ADDR_CAL_VCO_CUR:  o_rdata <= synth_cal_vco_current_q;
          `ADDR_MODE_CTRL:    o_rdata <= mode_ctrl_q;
          default:            o_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************
  // Power ramp sequencer
  // ****************************************
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_UP   = 4'h2;
  localparam [3:0] ST_HOLD = 4'h4;
  localparam [3:0] ST_DOWN = 4'h8;

  reg [3:0]            state_q;
  reg [TABLE_LOG2-1:0] step_q;
  reg [TABLE_LOG2-1:0] target;
  reg [TABLE_LOG2-1:0] pa_idx;

  // ****************************************
  // Keyed target selection
  // ****************************************
  // RL2: one symbol uses power index
  // RL3: zero symbol uses entry zero
  always @*
  begin
    target = power_index;
    if (ask_mode && !i_symbol)
    begin
      target = {TABLE_LOG2{1'b0}};
    end
  end

  // RL4: step one entry per cycle toward target
  // RL5: ramp up then down in all formats
  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      state_q <= ST_IDLE;
      step_q  <= {TABLE_LOG2{1'b0}};
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (i_tx_active)
          begin
            state_q <= ST_UP;
            step_q  <= {TABLE_LOG2{1'b0}};
          end
        end
        ST_UP:
        begin
          if (!i_tx_active)
          begin
            state_q <= ST_DOWN;
          end
          // At or above: an index lowered mid-ramp cannot wrap the step
          else if (step_q >= power_index)
          begin
            state_q <= ST_HOLD;
          end
          else
          begin
            step_q <= step_q + 1'b1;
          end
        end
        ST_HOLD:
        begin
          if (!i_tx_active)
          begin
            state_q <= ST_DOWN;
          end
          else if (step_q < target)
          begin
            step_q <= step_q + 1'b1;
          end
          else if (step_q > target)
          begin
            step_q <= step_q - 1'b1;
          end
        end
        ST_DOWN:
        begin
          if (step_q == {TABLE_LOG2{1'b0}})
          begin
            state_q <= ST_IDLE;
          end
          else
          begin
            step_q <= step_q - 1'b1;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Keyed shaping slews only while holding; plain mode holds at index
  always @*
  begin
    pa_idx = step_q;
  end

  // RL1: index addresses eight-entry table
  power_table_mem #(
    .DEPTH_LOG2 (TABLE_LOG2),
    .WIDTH      (8)
  ) u_table (
    .i_clock   (i_clock),
    .i_we      (table_we),
    .i_waddr   (i_addr[TABLE_LOG2-1:0]),
    .i_wdata   (i_wdata),
    .i_raddr_a (i_addr[TABLE_LOG2-1:0]),
    .o_rdata_a (table_rdata),
    .i_raddr_b (pa_idx),
    .o_rdata_b (table_pa_data)
  );

  // ****************************************
  // Analog control outputs
  // ****************************************
  wire [3:0] cp_code =
    synth_cal_charge_pump_q[`CP_CODE_MSB:`CP_CODE_LSB];
  reg        pa_live_q;

  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      pa_live_q       <= 1'b0;
      o_pa_setting    <= 8'h00;
      o_pa_on         <= 1'b0;
      o_cp_exp_int    <= 4'h0;
      o_cp_exp_frac   <= 2'h0;
      o_cp_cal_stage  <= 1'b0;
      o_osc_core_high <= 1'b0;
      o_osc_current   <= 5'h00;
      o_tx_lo_buf     <= 2'h0;
      o_rx_trims      <= 8'h00;
    end
    else
    begin
      // Table read adds a cycle; a delayed live flag keeps entry zero
      // on the pin for the last ramp-down step instead of cutting it
      pa_live_q       <= (state_q != ST_IDLE);
      o_pa_setting    <= pa_live_q ? table_pa_data : 8'h00;
      o_pa_on         <= pa_live_q;
      // RL7: integer and quarter parts of code/4
      o_cp_exp_int    <= {2'h0, cp_code[`CP_CODE_MSB:`CP_EXP_SHIFT]};
      o_cp_exp_frac   <= cp_code[`CP_EXP_SHIFT-1:0];
      // RL8: stage on only when field is one
      o_cp_cal_stage  <= (synth_cal_charge_pump_q
                          [`CP_CAL_EN_MSB:`CP_CAL_EN_LSB] == `CP_CAL_EN_ON);
      // RL9: core select
      o_osc_core_high <= synth_cal_vco_current_q[`VCO_HIGH_BIT];
      o_osc_current   <= synth_cal_vco_current_q[`VCO_CUR_MSB:`VCO_CUR_LSB];
      o_tx_lo_buf     <= tx_front_end_config_q[`TXLO_MSB:`TXLO_LSB];
      o_rx_trims      <= rx_front_end_config_q;
    end
  end

  // Table is write-only on the bus, so port A data is left unused;
  // reading it back would need a second read-data cycle
  wire unused_table = table_rd_q & (|table_rdata);
endmodule
`default_nettype wire

// >>> bench/pa_ramp_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "pa_ramp_consts.vh"
// ****
// Checker
// ****
module pa_ramp_properties #(
  parameter ADDR_W = 6
) (
  input  wire logic              i_clock,         // Clock
  input  wire logic              i_rst,           // Reset
  input  wire logic [ADDR_W-1:0] i_addr,          // Address
  input  wire logic [7:0]        i_wdata,         // Write data
  input  wire logic              i_wr,            // Write
  input  wire logic              i_rd,            // Read
  input  wire logic [7:0]        o_rdata,         // Read data
  input  wire logic              i_cal_load,      // Engine load
  input  wire logic [3:0]        i_cal_cp_code,   // Engine code
  input  wire logic [4:0]        i_cal_vco_cur,   // Engine current
  input  wire logic [3:0]        o_cp_exp_int,    // Exponent
  input  wire logic [1:0]        o_cp_exp_frac,   // Fraction
  input  wire logic              o_cp_cal_stage,  // Stage on
  input  wire logic              o_osc_core_high, // Core select
  input  wire logic [4:0]        o_osc_current,   // Current
  input  wire logic [1:0]        o_tx_lo_buf,     // Buffer
  input  wire logic [7:0]        o_rx_trims       // Trims
);
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [7:0] cp_q;
  logic [7:0] vco_q;
  logic [1:0] up_q;
  // Outputs may stay zero one edge past reset
  wire        ok = &up_q;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Engine load wins over a bus write
  always @(posedge i_clock)
  begin
    if (i_rst)
    begin
      rx_q  <= `RST_RX_FRONT_END;
      tx_q  <= `RST_TX_FRONT_END;
      cp_q  <= `RST_CAL_CHG_PUMP;
      vco_q <= `RST_CAL_VCO_CUR;
      up_q  <= 2'h0;
    end
    else
    begin
      up_q <= {up_q[0], 1'b1};
      if (i_wr && i_addr == `ADDR_RX_FRONT_END)
        rx_q <= i_wdata;
      if (i_wr && i_addr == `ADDR_TX_FRONT_END)
        tx_q <= i_wdata & `TX_WRITE_MASK;
      if (i_wr && i_addr == `ADDR_CAL_CHG_PUMP)
        cp_q <= i_wdata;
      if (i_wr && i_addr == `ADDR_CAL_VCO_CUR)
        vco_q <= i_wdata & `VCO_WRITE_MASK;
      if (i_cal_load)
      begin
        cp_q[3:0]  <= i_cal_cp_code;
        vco_q[4:0] <= i_cal_vco_cur;
      end
    end
  end
  a_read_idle_zero: assert property (
    !i_rd |=> o_rdata == 8'h00) else $error("idle read data not zero");
  a_read_tx_reg: assert property (
    i_rd && i_addr == `ADDR_TX_FRONT_END |=> o_rdata == $past(tx_q))
    else $error("tx register readback wrong");
  a_read_vco_reg: assert property (
    i_rd && i_addr == `ADDR_CAL_VCO_CUR |=> o_rdata == $past(vco_q))
    else $error("vco register readback wrong");
  a_rx_trim_copy: assert property (
    ok |-> o_rx_trims == $past(rx_q)) else $error("rx trims wrong");
  a_lo_buf_copy: assert property (
    ok |-> o_tx_lo_buf == $past(tx_q[5:4])) else $error("lo buffer wrong");
  a_cal_stage_on: assert property (
    ok |-> o_cp_cal_stage == ($past(cp_q[5:4]) == 2'h1))
    else $error("cal stage wrong");
  a_cp_exp_code: assert property (
    ok |-> {o_cp_exp_int, o_cp_exp_frac} == {2'h0, $past(cp_q[3:0])})
    else $error("exponent split wrong");
  a_osc_core_cur: assert property (
    ok |-> {o_osc_core_high, o_osc_current} == $past(vco_q[5:0]))
    else $error("oscillator outputs wrong");
endmodule
bind pa_ramp_index_and_synth_cal_regs pa_ramp_properties #(.ADDR_W(ADDR_W))
  u_props (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_cal_load(i_cal_load), .i_cal_cp_code(i_cal_cp_code),
  .i_cal_vco_cur(i_cal_vco_cur), .o_cp_exp_int(o_cp_exp_int),
  .o_cp_exp_frac(o_cp_exp_frac), .o_cp_cal_stage(o_cp_cal_stage),
  .o_osc_core_high(o_osc_core_high), .o_osc_current(o_osc_current),
  .o_tx_lo_buf(o_tx_lo_buf), .o_rx_trims(o_rx_trims));
`default_nettype wire

// >>> bench/pa_ramp_index_and_synth_cal_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
module pa_ramp_index_and_synth_cal_regs_test;
  logic       clk = 0, rst = 1, wr = 0, rd = 0, tx = 0, sym = 0, cl = 0;
  logic [5:0] a = 0;
  logic [7:0] d = 0, rdata, pa, trims, last;
  logic [3:0] cc = 0, ei;
  logic [4:0] vc = 0, oc;
  logic [1:0] ef, lo;
  logic       on, st, hi;
  int         n_fail = 0, samples_checked = 0, cyc = 0;
  logic [7:0] q[$];
  always #2 clk = ~clk;
  pa_ramp_index_and_synth_cal_regs dut (.i_clock(clk), .i_rst(rst),
    .i_addr(a), .i_wdata(d), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_tx_active(tx), .i_symbol(sym), .i_symbol_strobe(1'b0),
    .i_cal_load(cl), .i_cal_cp_code(cc), .i_cal_vco_cur(vc),
    .o_pa_setting(pa), .o_pa_on(on), .o_cp_exp_int(ei),
    .o_cp_exp_frac(ef), .o_cp_cal_stage(st), .o_osc_core_high(hi),
    .o_osc_current(oc), .o_tx_lo_buf(lo), .o_rx_trims(trims));
  // ****
  // Bus and check tasks
  // ****
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wrr(input logic [5:0] ad, input logic [7:0] v);
    @(posedge clk);
    wr <= 1;
    a <= ad;
    d <= v;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rdc(input logic [5:0] ad, input logic [7:0] e);
    @(posedge clk);
    rd <= 1;
    a <= ad;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rdc(6'h21, 8'h56);
    rdc(6'h22, 8'h10);
    rdc(6'h23, 8'hA9);
    rdc(6'h24, 8'h0A);
    rdc(6'h30, 8'h00);
  endtask
  task automatic t_regs;
    wrr(6'h21, 8'hFF);
    wrr(6'h22, 8'hFF);
    wrr(6'h23, 8'h1B);
    wrr(6'h24, 8'hFF);
    tick(1);
    chk(trims, 8'hFF);
    chk({6'h00, lo}, 8'h03);
    chk({ei, ef, st, hi}, 8'h2F);
    chk({3'h0, oc}, 8'h1F);
    rdc(6'h22, 8'h37);
    rdc(6'h24, 8'h3F);
  endtask
  task automatic t_cal;
    wrr(6'h23, 8'h9B);
    @(posedge clk);
    cl <= 1;
    cc <= 4'h5;
    vc <= 5'h13;
    @(posedge clk);
    cl <= 0;
    rdc(6'h23, 8'h95);
    rdc(6'h24, 8'h33);
    wrr(6'h23, 8'h1B);
    rdc(6'h23, 8'h1B);
    @(posedge clk);
    wr <= 1;
    a  <= 6'h23;
    d  <= 8'hE0;
    cl <= 1;
    cc <= 4'h7;
    vc <= 5'h04;
    @(posedge clk);
    wr <= 0;
    cl <= 0;
    rdc(6'h23, 8'hE7);
    rdc(6'h24, 8'h24);
  endtask
  task automatic grab(input int n);
    repeat (n)
    begin
      tick(1);
      if (pa !== last)
        q.push_back(pa);
      last = pa;
    end
  endtask
  task automatic t_ramp;
    for (int i = 0; i < 8; i++)
      wrr(6'h38 + 6'(i), 8'h11 * 8'(i + 1));
    rdc(6'h38, 8'h00);
    wrr(6'h22, 8'h17);
    last = 8'h00;
    @(posedge clk);
    tx <= 1;
    grab(14);
    @(posedge clk);
    tx <= 0;
    grab(14);
    chk(8'(q.size()), 8'h10);
    for (int i = 0; i < 8; i++)
      chk(q[i], 8'h11 * 8'(i + 1));
    for (int i = 0; i < 7; i++)
      chk(q[8 + i], 8'h11 * 8'(7 - i));
  endtask
  task automatic t_ask;
    wrr(6'h37, 8'hFF);
    rdc(6'h37, 8'h01);
    wrr(6'h22, 8'h12);
    @(posedge clk);
    sym <= 1;
    tx <= 1;
    tick(14);
    chk(pa, 8'h33);
    @(posedge clk);
    sym <= 0;
    tick(14);
    chk(pa, 8'h11);
    chk({7'h00, on}, 8'h01);
    @(posedge clk);
    tx <= 0;
    tick(14);
    chk({7'h00, on}, 8'h00);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 0;
    t_reset();
    t_regs();
    t_cal();
    t_ramp();
    t_ask();
    conclude();
  end
  // Cut a hang well past the expected run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      conclude();
    end
  end
endmodule
`default_nettype wire
